// ### src/pfp_cfg.svh
// Purpose: constants for the fault protection and propagation block
// Assumes: 10 MHz controller clock, millivolt and degree Celsius units
// Notes: offsets of the register port are local choices of this block
`ifndef PFP_CFG_SVH
`define PFP_CFG_SVH

// register port offsets
`define PFP_ADDR_FLAGS 2'h0
`define PFP_ADDR_MODE 2'h1
`define PFP_ADDR_PROP 2'h2
`define PFP_ADDR_STATE 2'h3

// reset values
`define PFP_FLAGS_RST 8'hFF
`define PFP_MODE_RST 8'h80
`define PFP_PROP_RST 8'h3F

// field positions shared by flags, mode latch bits and propagation enables
`define PFP_B_HEAT 7
`define PFP_B_WIN 6
`define PFP_B_RAMP 5
`define PFP_B_THERM 4
`define PFP_B_CUR 3
`define PFP_B_LOW 2
`define PFP_B_HIGH 1
`define PFP_B_PHASE 0
// mode register: ramp-deviation check enable and phase check enable
`define PFP_B_RAMP_EN 7
`define PFP_B_PHASE_EN 6

// thresholds
`define PFP_THERM_TRIP 8'h78
`define PFP_THERM_RESTART 8'h6E
`define PFP_HEAT_CLEAR 8'h75
`define PFP_RAMP_DEV_MV 13'h0FA
`define PFP_OV_PCT_LO 8'h6E
`define PFP_OV_PCT_MID 8'h78
`define PFP_OV_PCT_HI 8'h82
`define PFP_PCT_BASE 8'h64
// 1.0 V floor expressed in mV times the percent base
`define PFP_OV_FLOOR 24'h0186A0

// timing
`define PFP_CLK_KHZ 10000
`define PFP_HICCUP_MS 130

`endif

// ### src/pfp_hiccup.sv
// Purpose: restart interval timer
// Assumes: start is a one-cycle pulse
// Notes: expired stays high until the next start
`timescale 1ns/1ps
module pfp_hiccup #(
  parameter int unsigned CYC = 1300000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // control
  input wire logic start_i,
  output logic expired_o
);
  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic [CW-1:0] cnt_q; // cycles since start
  logic busy_q; // interval running

  // count from start; a new start restarts the interval
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      expired_o <= 1'b0;
    end else if (start_i) begin
      cnt_q <= '0;
      busy_q <= 1'b1;
      expired_o <= 1'b0;
    end else if (busy_q) begin
      if (cnt_q == LAST) begin
        busy_q <= 1'b0;
        expired_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule // pfp_hiccup

// ### src/pfp_pkg.sv
// Purpose: types of the fault protection and propagation block
// Assumes: nothing beyond the configuration header
// Notes: states use Gray codes along the shutdown path and the restart from latch
package pfp_pkg;

  // shutdown sequence states
  typedef enum logic [2:0] {
    PFP_S_RUN = 3'h0,
    PFP_S_DOWN = 3'h1,
    PFP_S_WAIT = 3'h3,
    PFP_S_LATCH = 3'h2
  } pfp_state_t;

  // which kind of turn-off is in force
  typedef enum logic [1:0] {
    PFP_K_REG = 2'h0,
    PFP_K_FAST = 2'h1,
    PFP_K_ERR = 2'h2
  } pfp_kind_t;

  // cause that started the shutdown
  typedef enum logic [2:0] {
    PFP_C_THERM = 3'h0,
    PFP_C_RAMP = 3'h1,
    PFP_C_CUR = 3'h2,
    PFP_C_LOW = 3'h3,
    PFP_C_HIGH = 3'h4,
    PFP_C_EXT = 3'h5
  } pfp_cause_t;

endpackage

// ### src/pfp_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs arrive asynchronously to the clock
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module pfp_sync #(
  parameter int unsigned W = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // pins in, synchronised out
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q; // first stage, metastability may settle here

  // two stages; reset value is the idle level of the pins
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_q <= rst_val_i;
      q_o <= rst_val_i;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // pfp_sync

// ### src/pfp_top.sv
// Purpose: protection detection, shutdown sequencing and group fault propagation
// Assumes: analog values arrive digitised on the controller clock
// Notes: the power stage itself honours delay and slew during a regular turn-off
`timescale 1ns/1ps
`include "pfp_cfg.svh"

// Summary of operation
// [R1] above 120C: thermal fault, flag 0, regular off
// [R2] non-latching thermal restarts below 110C
// [R3] ramp deviation checked only during ramp-up
// [R4] deviation over 250mV: flag 0, fast off
// [R5] mode register bit disables ramp deviation check
// [R6] past pre-bias, over threshold: high-output error
// [R7] high-output error: high side off, low on
// [R8] threshold 110 to 130 percent, floor 1.0V
// [R9] phase error source never raised
// [R10] shared group line is common fault signal
// [R11] enabled propagation pulls group line low
// [R12] group line low from others starts turn-off
// [R13] propagation register layout, warnings bits 7,6
// [R14] bit 1 enables high-output error propagation
// [R15] manager pulls other group lines on fault
// [R16] propagated fault gives receivers regular turn-off
// [R17] propagated error gives fast turn-off, low on; code gives fast off with the low side left off
// [R18] non-latching retry 130ms after output zero
// [R19] regular turn-off leaves delay, slew to stage
// [R20] latching stays off until flag restored, recycle
// [R21] collapse while current limiting: fast off
// [R22] steady-state low output: regular off
// [R23] most severe shutdown wins on coincidence; code lets an own regular cause win over a received error
// [R24] group line synchronised before use
module pfp_top #(
  parameter int unsigned VW = 13,
  parameter int unsigned HICCUP_CYC = `PFP_HICCUP_MS * `PFP_CLK_KHZ
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  // register port
  input wire logic REG_WR_I,
  input wire logic [1:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  // sensed values and phases
  input wire logic [7:0] TEMP_I,
  input wire logic [VW-1:0] VOUT_I,
  input wire logic [VW-1:0] VTARGET_I,
  input wire logic [VW-1:0] VSET_I,
  input wire logic [1:0] OV_LEVEL_I,
  input wire logic UV_BELOW_I,
  input wire logic ILIM_I,
  input wire logic RAMP_UP_I,
  input wire logic STEADY_I,
  input wire logic PREBIAS_DONE_I,
  input wire logic ZERO_OUT_I,
  input wire logic TURN_ON_I,
  input wire logic LINE_ERR_I,
  // power good pin
  input wire logic PGOOD_I,
  // group fault line, open drain
  input wire logic GFLT_I,
  output logic GFLT_O,
  output logic GFLT_OE_O,
  // power stage control
  output logic RUN_O,
  output logic REG_OFF_O,
  output logic FAST_OFF_O,
  output logic LS_ON_O,
  // warning reports to the manager
  output logic HEAT_WARN_O,
  output logic WINDOW_WARN_O
);
  // high-output compare scaled by the percent base, floor at 1.0 V
  function automatic logic ov_over(input logic [VW-1:0] v, input logic [VW-1:0] set,
                                   input logic [1:0] lvl);
    logic [7:0] pct;
    logic [23:0] lhs;
    logic [23:0] rhs;
    pct = (lvl == 2'h0) ? `PFP_OV_PCT_LO : (lvl == 2'h1) ? `PFP_OV_PCT_MID : `PFP_OV_PCT_HI;
    lhs = 24'(v) * 24'(`PFP_PCT_BASE);
    rhs = 24'(set) * 24'(pct);
    if (rhs < `PFP_OV_FLOOR) begin
      rhs = `PFP_OV_FLOOR;
    end
    return lhs > rhs;
  endfunction

  // absolute difference of two voltages
  function automatic logic [VW-1:0] abs_diff(input logic [VW-1:0] a, input logic [VW-1:0] b);
    return (a > b) ? VW'(a - b) : VW'(b - a);
  endfunction

  pfp_pkg::pfp_state_t state_q; // shutdown sequence state
  pfp_pkg::pfp_kind_t kind_q; // turn-off kind in force
  pfp_pkg::pfp_cause_t cause_q; // cause of the current shutdown
  logic [7:0] flags_q; // fault flag register, 0 marks an event
  logic [7:0] mode_q; // protection mode register
  logic [7:0] prop_q; // propagation configuration register
  logic pull_q; // this module is pulling the group line
  logic [1:0] pull_hist_q; // own pull one and two cycles ago
  logic latch_q; // current cause is latching
  logic recycled_q; // turn-on command cycled while latched
  logic ton_q; // turn-on command one cycle ago
  logic [1:0] pin_s; // synchronised {pgood, group line}
  logic line_low; // group line seen low
  logic pg_bad; // output outside power good window
  logic ev_therm, ev_ramp, ev_cur, ev_low, ev_high; // detections
  logic ov_trip; // raw high-output compare
  logic own_trip; // any own protection fires
  logic ext_trip; // another party pulls the line
  logic own_prop; // propagation enabled for the firing cause
  logic gone; // cause of the shutdown has gone
  logic expired; // restart interval elapsed
  logic hic_start; // start of restart interval
  logic wr_flags, wr_mode, wr_prop; // register write strobes

  // pins pass two flops before use; idle level is high for both
  pfp_sync #(.W(2)) u_sync (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .d_i({PGOOD_I, GFLT_I}), // [R24]
    .rst_val_i(2'h3),
    .q_o(pin_s)
  );
  assign line_low = !pin_s[0]; // [R10]
  assign pg_bad = !pin_s[1];

  // restart interval, long count kept as a parameter
  pfp_hiccup #(.CYC(HICCUP_CYC)) u_hiccup (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .start_i(hic_start),
    .expired_o(expired)
  );

  // detections, each but thermal armed only in its own phase
  assign ov_trip = ov_over(VOUT_I, VSET_I, OV_LEVEL_I); // [R8]
  assign ev_therm = TEMP_I > `PFP_THERM_TRIP; // [R1]
  assign ev_ramp = RAMP_UP_I && mode_q[`PFP_B_RAMP_EN] &&
                   (abs_diff(VOUT_I, VTARGET_I) > `PFP_RAMP_DEV_MV); // [R3] [R4] [R5]
  assign ev_high = PREBIAS_DONE_I && ov_trip; // [R6]
  assign ev_cur = PREBIAS_DONE_I && ILIM_I && UV_BELOW_I; // [R21]
  assign ev_low = STEADY_I && UV_BELOW_I && !ev_cur; // [R22]
  assign own_trip = ev_therm || ev_ramp || ev_high || ev_cur || ev_low;
  // own pull and its two-cycle echo through the synchroniser are not answered
  assign ext_trip = line_low && !pull_q && (pull_hist_q == 2'h0); // [R12]

  // propagation enable for the most severe firing cause
  always_comb begin
    if (ev_high) begin
      own_prop = prop_q[`PFP_B_HIGH]; // [R14]
    end else if (ev_cur || ev_ramp) begin
      own_prop = (ev_cur && prop_q[`PFP_B_CUR]) || (ev_ramp && prop_q[`PFP_B_RAMP]);
    end else begin
      own_prop = (ev_therm && prop_q[`PFP_B_THERM]) || (ev_low && prop_q[`PFP_B_LOW]); // [R13]
    end
  end

  // has the cause gone; thermal waits for the lower threshold
  always_comb begin
    unique case (cause_q)
      pfp_pkg::PFP_C_THERM: gone = TEMP_I < `PFP_THERM_RESTART; // [R2]
      pfp_pkg::PFP_C_CUR: gone = !ILIM_I;
      pfp_pkg::PFP_C_HIGH: gone = !ov_trip;
      pfp_pkg::PFP_C_EXT: gone = !line_low;
      default: gone = 1'b1; // ramp and low-output clear with the phase
    endcase
  end

  assign hic_start = (state_q == pfp_pkg::PFP_S_DOWN) && ZERO_OUT_I; // [R18]

  // shutdown sequencer with severity order error, fast, regular among own causes, received causes last
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      state_q <= pfp_pkg::PFP_S_RUN;
      kind_q <= pfp_pkg::PFP_K_REG;
      cause_q <= pfp_pkg::PFP_C_THERM;
      latch_q <= 1'b0;
    end else begin
      unique case (state_q)
        pfp_pkg::PFP_S_RUN: begin
          if (own_trip || ext_trip) begin
            state_q <= pfp_pkg::PFP_S_DOWN;
            if (ev_high) begin
              kind_q <= pfp_pkg::PFP_K_ERR; // [R7] [R23]
              cause_q <= pfp_pkg::PFP_C_HIGH;
              latch_q <= mode_q[`PFP_B_HIGH];
            end else if (ev_cur || ev_ramp) begin
              kind_q <= pfp_pkg::PFP_K_FAST; // [R4] [R21] [R23]
              cause_q <= ev_cur ? pfp_pkg::PFP_C_CUR : pfp_pkg::PFP_C_RAMP;
              latch_q <= ev_cur ? mode_q[`PFP_B_CUR] : mode_q[`PFP_B_RAMP];
            end else if (ev_therm || ev_low) begin
              kind_q <= pfp_pkg::PFP_K_REG; // [R1] [R22]
              cause_q <= ev_therm ? pfp_pkg::PFP_C_THERM : pfp_pkg::PFP_C_LOW;
              latch_q <= ev_therm ? mode_q[`PFP_B_THERM] : mode_q[`PFP_B_LOW];
            end else begin
              // received: error signalled as fast, fault as regular
              kind_q <= LINE_ERR_I ? pfp_pkg::PFP_K_FAST : pfp_pkg::PFP_K_REG; // [R16] [R17]
              cause_q <= pfp_pkg::PFP_C_EXT;
              latch_q <= 1'b0;
            end
          end
        end
        pfp_pkg::PFP_S_DOWN: begin
          // the stage ramps down by its own delay and slew first
          if (ZERO_OUT_I) begin
            state_q <= pfp_pkg::PFP_S_WAIT; // [R19]
          end
        end
        pfp_pkg::PFP_S_WAIT: begin
          if (expired && latch_q) begin
            state_q <= pfp_pkg::PFP_S_LATCH; // [R20]
          end else if (expired && gone) begin
            state_q <= pfp_pkg::PFP_S_RUN; // [R18] [R2]
          end
        end
        pfp_pkg::PFP_S_LATCH: begin
          // restore needs a turn-on recycle, or the cause gone and the flag written back
          if (recycled_q) begin
            state_q <= pfp_pkg::PFP_S_RUN; // [R20]
          end else if (gone && (cause_q == pfp_pkg::PFP_C_THERM ? flags_q[`PFP_B_THERM] :
                                cause_q == pfp_pkg::PFP_C_RAMP ? flags_q[`PFP_B_RAMP] :
                                cause_q == pfp_pkg::PFP_C_CUR ? flags_q[`PFP_B_CUR] :
                                cause_q == pfp_pkg::PFP_C_LOW ? flags_q[`PFP_B_LOW] :
                                flags_q[`PFP_B_HIGH])) begin
            state_q <= pfp_pkg::PFP_S_RUN; // [R20]
          end
        end
      endcase
    end
  end

  // turn-on command cycling releases a latched shutdown
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      ton_q <= 1'b0;
      recycled_q <= 1'b0;
    end else begin
      ton_q <= TURN_ON_I;
      if (state_q != pfp_pkg::PFP_S_LATCH) begin
        recycled_q <= 1'b0;
      end else if (ton_q && !TURN_ON_I) begin
        recycled_q <= 1'b1; // [R20]
      end
    end
  end

  // pull the group line while an own propagated shutdown lasts
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      pull_q <= 1'b0;
      pull_hist_q <= 2'h0;
    end else begin
      pull_hist_q <= {pull_hist_q[0], pull_q};
      if (state_q == pfp_pkg::PFP_S_RUN) begin
        pull_q <= own_trip && own_prop; // [R11]
      end
    end
  end
  assign GFLT_O = 1'b0;
  assign GFLT_OE_O = pull_q; // [R11]

  // register write strobes
  assign wr_flags = REG_WR_I && (REG_ADDR_I == `PFP_ADDR_FLAGS);
  assign wr_mode = REG_WR_I && (REG_ADDR_I == `PFP_ADDR_MODE);
  assign wr_prop = REG_WR_I && (REG_ADDR_I == `PFP_ADDR_PROP);

  // fault flags: events force 0 and win over a software write of 1
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      flags_q <= `PFP_FLAGS_RST;
    end else begin
      for (int i = `PFP_B_HIGH; i <= `PFP_B_RAMP; i++) begin
        if (wr_flags && REG_WDATA_I[i]) begin
          flags_q[i] <= 1'b1;
        end
      end
      if (ev_therm) flags_q[`PFP_B_THERM] <= 1'b0; // [R1]
      if (ev_ramp) flags_q[`PFP_B_RAMP] <= 1'b0; // [R4]
      if (ev_cur) flags_q[`PFP_B_CUR] <= 1'b0; // [R21]
      if (ev_low) flags_q[`PFP_B_LOW] <= 1'b0; // [R22]
      if (ev_high) flags_q[`PFP_B_HIGH] <= 1'b0; // [R6]
      flags_q[`PFP_B_PHASE] <= 1'b1; // [R9]
      // warnings are set and cleared by hardware only
      if (ev_therm) begin
        flags_q[`PFP_B_HEAT] <= 1'b0;
      end else if (TEMP_I < `PFP_HEAT_CLEAR) begin
        flags_q[`PFP_B_HEAT] <= 1'b1;
      end
      flags_q[`PFP_B_WIN] <= !(pg_bad && STEADY_I);
    end
  end

  // configuration registers
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      mode_q <= `PFP_MODE_RST;
      prop_q <= `PFP_PROP_RST;
    end else begin
      if (wr_mode) mode_q <= REG_WDATA_I; // [R5]
      if (wr_prop) prop_q <= REG_WDATA_I; // [R13]
    end
  end

  // registered read data; state register shows sequencer state
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      REG_RDATA_O <= 8'h00;
    end else begin
      unique case (REG_ADDR_I)
        `PFP_ADDR_FLAGS: REG_RDATA_O <= flags_q;
        `PFP_ADDR_MODE: REG_RDATA_O <= mode_q;
        `PFP_ADDR_PROP: REG_RDATA_O <= prop_q;
        `PFP_ADDR_STATE: REG_RDATA_O <= {pull_q, line_low, kind_q, 1'b0, state_q};
      endcase
    end
  end

  // power stage controls decoded from sequencer flops, run also from the turn-on command
  assign RUN_O = (state_q == pfp_pkg::PFP_S_RUN) && TURN_ON_I;
  assign REG_OFF_O = (state_q != pfp_pkg::PFP_S_RUN) && (kind_q == pfp_pkg::PFP_K_REG); // [R19]
  assign FAST_OFF_O = (state_q != pfp_pkg::PFP_S_RUN) && (kind_q != pfp_pkg::PFP_K_REG);
  assign LS_ON_O = (state_q != pfp_pkg::PFP_S_RUN) && (kind_q == pfp_pkg::PFP_K_ERR); // [R7]

  // warning reports gated by propagation register bits 7 and 6
  assign HEAT_WARN_O = prop_q[`PFP_B_HEAT] && !flags_q[`PFP_B_HEAT]; // [R13]
  assign WINDOW_WARN_O = prop_q[`PFP_B_WIN] && !flags_q[`PFP_B_WIN]; // [R13]

  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  a_therm_trip_off: assert property ( // [R1]
    state_q == pfp_pkg::PFP_S_RUN && ev_therm && !ev_high && !ev_cur && !ev_ramp
    |=> state_q == pfp_pkg::PFP_S_DOWN && REG_OFF_O && !FAST_OFF_O)
    else $error("thermal fault did not start regular turn-off");
  a_therm_flag_low: assert property (ev_therm |=> !flags_q[`PFP_B_THERM]) // [R1]
    else $error("thermal flag not cleared to 0");
  a_ramp_phase_only: assert property (!RAMP_UP_I || !mode_q[`PFP_B_RAMP_EN] |-> !ev_ramp) // [R3]
    else $error("ramp deviation raised outside ramp or while disabled");
  a_ramp_fast_off: assert property ( // [R4]
    state_q == pfp_pkg::PFP_S_RUN && ev_ramp && !ev_high
    |=> FAST_OFF_O && !LS_ON_O && !RUN_O)
    else $error("ramp deviation did not give fast turn-off");
  a_high_low_side: assert property ( // [R7]
    state_q == pfp_pkg::PFP_S_RUN && ev_high |=> FAST_OFF_O && LS_ON_O ##1 LS_ON_O)
    else $error("high-output error did not turn low side on");
  a_ov_floor_hold: assert property (VOUT_I <= VW'(1000) |-> !ov_trip) // [R8]
    else $error("high-output threshold below 1.0V");
  a_phase_never_set: assert property (##1 flags_q[`PFP_B_PHASE]) // [R9]
    else $error("phase error flag raised");
  a_pull_line_low: assert property ( // [R11]
    state_q == pfp_pkg::PFP_S_RUN && own_trip && own_prop |=> GFLT_OE_O && !GFLT_O)
    else $error("group line not pulled on propagated fault");
  a_ext_turn_off: assert property ( // [R12]
    state_q == pfp_pkg::PFP_S_RUN && ext_trip |=> state_q == pfp_pkg::PFP_S_DOWN)
    else $error("group line low did not start turn-off");
  a_retry_wait: assert property ( // [R18]
    hic_start |=> !expired [*8])
    else $error("restart interval ended too early");

  c_high_error: cover property (state_q == pfp_pkg::PFP_S_RUN && ev_high);
  c_hiccup_back: cover property (state_q == pfp_pkg::PFP_S_WAIT ##1 state_q == pfp_pkg::PFP_S_RUN);
  c_latched: cover property (state_q == pfp_pkg::PFP_S_LATCH);
  c_ext_fast: cover property (state_q == pfp_pkg::PFP_S_RUN && ext_trip && LINE_ERR_I);
endmodule // pfp_top

// ### verif/pfp_grp_partner.sv
// Purpose: behavioural model of the other group members and the power manager
// Assumes: group line has a pull-up; members only ever pull it low
// Notes: combinational wired-and, so a pull shows in the same cycle
`timescale 1ns/1ps
module pfp_grp_partner (
  // other member pulling the line
  input wire logic pull_i,
  // device side of the open-drain pin
  input wire logic dev_oe_i,
  input wire logic dev_o_i,
  // resolved line and the manager's pull on another group
  output logic line_o,
  output logic other_pull_o
);
  // pull-up wins only while nobody pulls; a pulled line reads 0, never stale
  assign line_o = ~(pull_i | (dev_oe_i & ~dev_o_i));
  // manager pulls the other group's line whenever this one is low
  assign other_pull_o = ~line_o;
endmodule // pfp_grp_partner

// ### verif/tb_protection_fault_propagation.sv
// Purpose: self-checking bench for protection detection and group propagation
// Assumes: restart interval shortened to 20 cycles
// Notes: trips are checked as {heat warn, window warn, regular off, fast off, low side, pull}
`timescale 1ns/1ps
module tb_protection_fault_propagation;
  logic SYS_CLK_I, RSTN_I, REG_WR_I, UV_BELOW_I, ILIM_I, RAMP_UP_I, STEADY_I;
  logic PREBIAS_DONE_I, ZERO_OUT_I, TURN_ON_I, LINE_ERR_I, PGOOD_I, pull;
  logic [1:0] REG_ADDR_I, OV_LEVEL_I;
  logic [7:0] REG_WDATA_I, REG_RDATA_O, TEMP_I, seed, stage;
  logic [12:0] VOUT_I, VTARGET_I, VSET_I;
  logic GFLT_O, GFLT_OE_O, RUN_O, REG_OFF_O, FAST_OFF_O, LS_ON_O, line;
  logic HEAT_WARN_O, WINDOW_WARN_O;
  int err_total, checked, cyc, lim;
  assign stage = {2'h0, HEAT_WARN_O, WINDOW_WARN_O, REG_OFF_O, FAST_OFF_O, LS_ON_O, GFLT_OE_O};
  // device under test with a short restart interval
  pfp_top #(.HICCUP_CYC(20)) uut (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I),
    .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_RDATA_O(REG_RDATA_O), .TEMP_I(TEMP_I), .VOUT_I(VOUT_I), .VTARGET_I(VTARGET_I),
    .VSET_I(VSET_I), .OV_LEVEL_I(OV_LEVEL_I), .UV_BELOW_I(UV_BELOW_I), .ILIM_I(ILIM_I),
    .RAMP_UP_I(RAMP_UP_I), .STEADY_I(STEADY_I), .PREBIAS_DONE_I(PREBIAS_DONE_I),
    .ZERO_OUT_I(ZERO_OUT_I), .TURN_ON_I(TURN_ON_I), .LINE_ERR_I(LINE_ERR_I),
    .PGOOD_I(PGOOD_I), .GFLT_I(line), .GFLT_O(GFLT_O), .GFLT_OE_O(GFLT_OE_O),
    .RUN_O(RUN_O), .REG_OFF_O(REG_OFF_O), .FAST_OFF_O(FAST_OFF_O), .LS_ON_O(LS_ON_O),
    .HEAT_WARN_O(HEAT_WARN_O), .WINDOW_WARN_O(WINDOW_WARN_O));
  // far side of the group line
  pfp_grp_partner peer (.pull_i(pull), .dev_oe_i(GFLT_OE_O), .dev_o_i(GFLT_O),
    .line_o(line), .other_pull_o());
  // 10 MHz clock
  initial begin
    SYS_CLK_I = 1'b0;
    forever #50 SYS_CLK_I = ~SYS_CLK_I;
  end
  // hang guard: far above the few hundred cycles the run needs
  always @(posedge SYS_CLK_I) begin
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      err_total++;
      print_verdict();
    end
  end
  // repeatable pseudo-random source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // highest non-tripping output: setpoint percentage, never under the 1.0 V floor
  function automatic int ovlim(input int vset, input int lvl);
    int pct;
    pct = (lvl == 0) ? 110 : (lvl == 1) ? 120 : 130;
    return ((vset * pct > 100000) ? vset * pct : 100000) / 100;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK_I);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    REG_WR_I <= 1'b1;
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    tick(1);
    REG_WR_I <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    REG_ADDR_I <= a;
    tick(2);
    chk(REG_RDATA_O, exp);
  endtask
  // remove every cause, finish the ramp-down, then time the restart
  task automatic recover();
    TEMP_I <= 8'h19;
    VOUT_I <= 13'h0000;
    VTARGET_I <= 13'h0000;
    RAMP_UP_I <= 1'b0;
    STEADY_I <= 1'b0;
    UV_BELOW_I <= 1'b0;
    ILIM_I <= 1'b0;
    PREBIAS_DONE_I <= 1'b0;
    pull <= 1'b0;
    PGOOD_I <= 1'b1;
    ZERO_OUT_I <= 1'b1;
    tick(1);
    ZERO_OUT_I <= 1'b0;
    tick(15);
    chk({7'h00, RUN_O}, 8'h00);
    tick(15);
    chk({7'h00, RUN_O}, 8'h01);
    wr(2'h0, 8'h3E);
    rd(2'h0, 8'hFF);
  endtask
  // causes already applied: check stage outputs and flags, then restart
  task automatic trip(input logic [7:0] st, input logic [7:0] fl);
    tick(4);
    chk(stage, st);
    rd(2'h0, fl);
    recover();
  endtask
  task automatic quiet();
    tick(3);
    chk(stage, 8'h00);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {REG_WR_I, UV_BELOW_I, ILIM_I, RAMP_UP_I, STEADY_I, PREBIAS_DONE_I} = 6'h00;
    {ZERO_OUT_I, LINE_ERR_I, pull, REG_ADDR_I, OV_LEVEL_I} = 7'h00;
    {TURN_ON_I, PGOOD_I, RSTN_I} = 3'h6;
    {REG_WDATA_I, TEMP_I, seed} = {8'h00, 8'h19, 8'h26};
    {VOUT_I, VTARGET_I, VSET_I} = {13'h0000, 13'h0000, 13'h03E8};
    err_total = 0;
    checked = 0;
    cyc = 0;
    tick(4);
    RSTN_I <= 1'b1;
    tick(2);
    // reset values, layout, read-only state register
    rd(2'h0, 8'hFF);
    rd(2'h1, 8'h80);
    rd(2'h2, 8'h3F);
    wr(2'h2, 8'hA5);
    rd(2'h2, 8'hA5);
    wr(2'h3, 8'h5A);
    rd(2'h3, 8'h00);
    // heat warning reporting on from here
    wr(2'h2, 8'hBF);
    // overtemperature: regular off, propagated, heat warning reported
    TEMP_I <= 8'h79;
    trip(8'h29, 8'h6F);
    // ramp deviation: 250 mV holds, 251 trips fast
    {RAMP_UP_I, VTARGET_I, VOUT_I} <= {1'b1, 13'h03E8, 13'h04E2};
    quiet();
    VOUT_I <= 13'h02ED;
    trip(8'h05, 8'hDF);
    {VTARGET_I, VOUT_I} <= {13'h03E8, 13'h0100};
    quiet();
    wr(2'h1, 8'h00);
    {RAMP_UP_I, VTARGET_I, VOUT_I} <= {1'b1, 13'h03E8, 13'h0100};
    quiet();
    {RAMP_UP_I, VTARGET_I, VOUT_I} <= {1'b0, 13'h0000, 13'h0000};
    quiet();
    chk({7'h00, RUN_O}, 8'h01);
    rd(2'h1, 8'h00);
    rd(2'h0, 8'hFF);
    wr(2'h1, 8'h80);
    // overvoltage at each level, random setpoints, floor corner first
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      lim = ovlim((i == 0) ? 500 : 500 + seed * 16, i % 4);
      if (i == 4) wr(2'h2, 8'h3D);
      {PREBIAS_DONE_I, OV_LEVEL_I} <= {1'b1, 2'(i % 4)};
      VSET_I <= (i == 0) ? 13'h01F4 : 13'(500 + seed * 16);
      VOUT_I <= 13'(lim);
      quiet();
      VOUT_I <= 13'(lim + 1);
      trip((i == 4) ? 8'h06 : 8'h07, 8'hFD);
    end
    // all propagation and both warning reports on
    wr(2'h2, 8'hFF);
    // collapse while current limiting, then steady-state undervoltage
    {PREBIAS_DONE_I, ILIM_I, UV_BELOW_I} <= 3'h7;
    trip(8'h05, 8'hF7);
    // power good pin low in steady state also raises the window warning
    {STEADY_I, UV_BELOW_I, PGOOD_I} <= 3'h6;
    trip(8'h19, 8'hBB);
    // another member pulls the line: regular, then error-type fast
    pull <= 1'b1;
    trip(8'h08, 8'hFF);
    {pull, LINE_ERR_I} <= 2'h3;
    trip(8'h04, 8'hFF);
    // latching thermal: stays off past the interval until the flag is restored
    wr(2'h1, 8'h90);
    TEMP_I <= 8'h79;
    tick(4);
    chk(stage, 8'h29);
    rd(2'h0, 8'h6F);
    {TEMP_I, ZERO_OUT_I} <= {8'h19, 1'b1};
    tick(1);
    ZERO_OUT_I <= 1'b0;
    tick(30);
    chk({7'h00, RUN_O}, 8'h00);
    rd(2'h3, 8'hC2);
    wr(2'h0, 8'h3E);
    tick(2);
    chk({7'h00, RUN_O}, 8'h01);
    print_verdict();
  end
endmodule // tb_protection_fault_propagation
